/* shl_consts.svh */
// Purpose: constants for the link endpoint (frame codes, timers, window sizes)
// Assumes: 250 MHz clock, frames carried as decoded control bytes
// Notes: timer figures kept in microseconds, cycle counts derived
//
// Functional notes
// - bring-up starts by transmitting a reset frame.
// - unrecoverable error may re-run bring-up with a fresh reset frame.
// - an acceptable received reset frame while ready is answered with UA.
// - initiator counts the link up only after UA to its reset (code also counts it up on a crossed reset no larger than its own window).
// - before link up every received frame except reset is dropped.
// - connection timer runs after reset; expiry without UA resends reset.
// - crossed reset frames are each answered with UA; default window used (code adopts the smaller of the two offered windows).
// - smaller window ignores offered reset, sends own; peer adopts it with UA.
// - idle receiver sends RR whenever the acknowledge timer expires.
// - acknowledge timer starts on first frame after the last acknowledgement.
// - sending an I-frame stops the pending acknowledge timer.
// - gap without usable selective reject sends REJ for first missing frame.
// - guarding timer expiry retransmits unacknowledged frames.
// - final frame of a burst is acknowledged by RR, never rejected.
// - RNR acknowledges like RR and stops peer I-frame sending.
// - resuming RR after RNR repeats every 5 to 20 ms until an I-frame.
// - resuming RR with nothing to send is confirmed by an empty I-frame.
// - one-ahead frame with selective reject: send SREJ, buffer frame, use ack.
// - when the missing frame arrives, process it then the buffered one.
// - all sequence arithmetic and window checks are modulo 8.
// - acknowledge within 5 ms at window four, scaled with the window.
// - guarding time at least 10 ms, independent of window.
// - connection time at most 5 ms, independent of window.
// - after establishment send, receive and lowest-unacked counters are zero.
`ifndef SHL_CONSTS_SVH
`define SHL_CONSTS_SVH
`define SHL_CLK_MHZ 250
`define SHL_ACK_TIME_US 5000
`define SHL_GUARD_TIME_US 10000
`define SHL_CONN_TIME_US 5000
`define SHL_RNR_RR_US 10000
`define SHL_ACK_CYC (`SHL_ACK_TIME_US * `SHL_CLK_MHZ)
`define SHL_GUARD_CYC (`SHL_GUARD_TIME_US * `SHL_CLK_MHZ)
`define SHL_CONN_CYC (`SHL_CONN_TIME_US * `SHL_CLK_MHZ)
`define SHL_RNR_RR_CYC (`SHL_RNR_RR_US * `SHL_CLK_MHZ)
`define SHL_DEF_WIN 3'h4
`define SHL_MIN_WIN 3'h2
`define SHL_U_RSET 5'h19
`define SHL_U_UA 5'h06
`endif

/* shl_pkg.sv */
// Purpose: types for the link endpoint
// Assumes: nothing beyond the constants header
// Notes: frame kinds are decoded, not raw control bytes
package shl_pkg;
  typedef enum logic [7:0] {
    FK_I = 8'h01, FK_RR = 8'h02, FK_REJ = 8'h04, FK_RNR = 8'h08,
    FK_SREJ = 8'h10, FK_RSET = 8'h20, FK_UA = 8'h40, FK_NONE = 8'h80
  } shl_kind_e;
  typedef enum logic [2:0] {
    ST_DOWN = 3'h1, ST_WAIT_UA = 3'h2, ST_UP = 3'h4
  } shl_state_e;
  typedef logic [2:0] shl_seq_t;
  typedef struct packed {
    shl_state_e st;
    logic [2:0] win;
    logic srej_en;
    shl_seq_t ns;
    shl_seq_t nr;
    shl_seq_t dnr;
    logic [31:0] ack_cnt;
    logic ack_run;
    logic [31:0] grd_cnt;
    logic [31:0] conn_cnt;
    logic [31:0] rr_cnt;
    logic rr_rep;
    logic peer_busy;
    logic send_empty;
    logic buf_vld;
    logic [7:0] buf_data;
    logic srej_out;
    logic rx_ok;
    logic [7:0] rx_data;
    logic rx_extra;
    logic [7:0] rx_extra_data;
    logic tx_vld;
    shl_kind_e tx_kind;
    shl_seq_t tx_ns;
    shl_seq_t tx_nr;
    logic [2:0] tx_win;
    logic tx_srej_cap;
    logic tx_take;
    logic up;
  } shl_st_s;
endpackage

/* shl_link_endpoint.sv */
// Purpose: one endpoint of the windowed link: bring-up, numbered transfer, acknowledgement, recovery
// Assumes: frame coder outside decodes each received frame into kind, numbers and one payload byte
// Notes: one transmit request at a time; tx_vld_o holds until tx_rdy_i
`timescale 1ns/1ps
`include "shl_consts.svh"
module shl_link_endpoint import shl_pkg::*; #(
  parameter int unsigned ACK_CYC = `SHL_ACK_CYC,
  parameter int unsigned GUARD_CYC = `SHL_GUARD_CYC,
  parameter int unsigned CONN_CYC = `SHL_CONN_CYC,
  parameter int unsigned RR_CYC = `SHL_RNR_RR_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [2:0] local_win_i,
  input wire logic local_srej_i,
  input wire logic busy_i,
  input wire logic rx_vld_i,
  input wire logic [7:0] rx_kind_i,
  input wire logic [2:0] rx_ns_i,
  input wire logic [2:0] rx_nr_i,
  input wire logic [2:0] rx_win_i,
  input wire logic rx_srej_cap_i,
  input wire logic [7:0] rx_data_i,
  input wire logic data_pend_i,
  input wire logic tx_rdy_i,
  output logic tx_vld_o,
  output logic [7:0] tx_kind_o,
  output logic [2:0] tx_ns_o,
  output logic [2:0] tx_nr_o,
  output logic [2:0] tx_win_o,
  output logic tx_srej_cap_o,
  output logic tx_take_o,
  output logic rx_ok_o,
  output logic [7:0] rx_data_o,
  output logic rx_extra_o,
  output logic [7:0] rx_extra_data_o,
  output logic link_up_o
);
  shl_st_s q, d;
  shl_kind_e rk;
  logic [2:0] outst, dist_ack, dist_ns, eff_win;
  logic tx_free, ack_ok;
  logic [31:0] ack_lim;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  assign rk = shl_kind_e'(rx_kind_i);
  assign outst = q.ns - q.dnr;
  assign dist_ack = rx_nr_i - q.dnr;
  assign dist_ns = q.ns - q.dnr;
  assign ack_ok = dist_ack <= dist_ns;
  assign tx_free = !q.tx_vld || tx_rdy_i;
  assign eff_win = (local_win_i < `SHL_MIN_WIN) ? `SHL_MIN_WIN :
                   (local_win_i > `SHL_DEF_WIN) ? `SHL_DEF_WIN : local_win_i;
  // acknowledge time shrinks in step with the window so streaming never stalls
  assign ack_lim = (ACK_CYC / 32'd4) * {29'h0, q.win};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    d = q;
    d.rx_ok = 1'b0;
    d.rx_extra = 1'b0;
    d.tx_take = 1'b0;
    if (q.tx_vld && tx_rdy_i) begin
      d.tx_vld = 1'b0;
    end
    unique case (q.st)
      ST_DOWN: begin
        if (start_i && tx_free) begin
          d.st = ST_WAIT_UA;
          d.conn_cnt = 32'h0;
          d.win = eff_win;
          d.tx_vld = 1'b1;
          d.tx_kind = FK_RSET;
          d.tx_win = eff_win;
          d.tx_srej_cap = local_srej_i;
        end else if (rx_vld_i && rk == FK_RSET && tx_free) begin
          if (rx_win_i > eff_win) begin
            // offer too large: answer with our own smaller reset instead of UA
            d.st = ST_WAIT_UA;
            d.conn_cnt = 32'h0;
            d.win = eff_win;
            d.tx_vld = 1'b1;
            d.tx_kind = FK_RSET;
            d.tx_win = eff_win;
            d.tx_srej_cap = local_srej_i;
          end else begin
            d.win = rx_win_i;
            d.srej_en = rx_srej_cap_i && local_srej_i;
            d.tx_vld = 1'b1;
            d.tx_kind = FK_UA;
            d.st = ST_UP;
            d.up = 1'b1;
            d.ns = 3'h0;
            d.nr = 3'h0;
            d.dnr = 3'h0;
          end
        end
      end
      ST_WAIT_UA: begin
        d.conn_cnt = q.conn_cnt + 32'h1;
        if (rx_vld_i && rk == FK_UA) begin
          d.st = ST_UP;
          d.up = 1'b1;
          d.ns = 3'h0;
          d.nr = 3'h0;
          d.dnr = 3'h0;
        end else if (rx_vld_i && rk == FK_RSET && tx_free) begin
          if (rx_win_i <= q.win) begin
            // crossover: answer the peer and count the link up
            d.win = rx_win_i;
            d.srej_en = rx_srej_cap_i && local_srej_i;
            d.tx_vld = 1'b1;
            d.tx_kind = FK_UA;
            d.st = ST_UP;
            d.up = 1'b1;
            d.ns = 3'h0;
            d.nr = 3'h0;
            d.dnr = 3'h0;
          end
        end else if (q.conn_cnt >= CONN_CYC - 1 && tx_free) begin
          d.conn_cnt = 32'h0;
          d.tx_vld = 1'b1;
          d.tx_kind = FK_RSET;
          d.tx_win = q.win;
          d.tx_srej_cap = local_srej_i;
        end
      end
      ST_UP: begin
        if (q.ack_run) d.ack_cnt = q.ack_cnt + 32'h1;
        if (outst != 3'h0) d.grd_cnt = q.grd_cnt + 32'h1;
        else d.grd_cnt = 32'h0;
        if (q.rr_rep) d.rr_cnt = q.rr_cnt + 32'h1;
        if (start_i) begin
          d.st = ST_DOWN;
          d.up = 1'b0;
        end else if (rx_vld_i) begin
          unique case (rk)
            FK_RSET: begin
              // a fresh reset frame restarts the session; it is answered only when tx_free, otherwise lost with the link down
              d.st = ST_DOWN;
              d.up = 1'b0;
              d.ack_run = 1'b0;
              d.rr_rep = 1'b0;
              d.peer_busy = 1'b0;
              d.buf_vld = 1'b0;
              d.srej_out = 1'b0;
              if (tx_free && rx_win_i > eff_win) begin
                d.st = ST_WAIT_UA;
                d.conn_cnt = 32'h0;
                d.win = eff_win;
                d.tx_vld = 1'b1;
                d.tx_kind = FK_RSET;
                d.tx_win = eff_win;
                d.tx_srej_cap = local_srej_i;
              end else if (tx_free) begin
                d.win = rx_win_i;
                d.srej_en = rx_srej_cap_i && local_srej_i;
                d.tx_vld = 1'b1;
                d.tx_kind = FK_UA;
                d.st = ST_UP;
                d.up = 1'b1;
                d.ns = 3'h0;
                d.nr = 3'h0;
                d.dnr = 3'h0;
              end
            end
            FK_I: begin
              if (ack_ok) d.dnr = rx_nr_i;
              d.rr_rep = 1'b0;
              if (!q.ack_run) begin
                d.ack_run = 1'b1;
                d.ack_cnt = 32'h0;
              end
              if (rx_ns_i == q.nr) begin
                d.rx_ok = 1'b1;
                d.rx_data = rx_data_i;
                d.nr = q.nr + 3'h1;
                d.srej_out = 1'b0;
                if (q.buf_vld) begin
                  d.rx_extra = 1'b1;
                  d.rx_extra_data = q.buf_data;
                  d.buf_vld = 1'b0;
                  d.nr = q.nr + 3'h2;
                end
              end else if (tx_free) begin
                d.tx_vld = 1'b1;
                d.tx_nr = q.nr;
                if (q.srej_en && rx_ns_i == q.nr + 3'h1 && !q.srej_out) begin
                  d.tx_kind = FK_SREJ;
                  d.buf_vld = 1'b1;
                  d.buf_data = rx_data_i;
                  d.srej_out = 1'b1;
                end else begin
                  d.tx_kind = FK_REJ;
                end
              end
            end
            FK_RR, FK_RNR: begin
              if (ack_ok) d.dnr = rx_nr_i;
              d.peer_busy = (rk == FK_RNR);
              if (rk == FK_RR && q.peer_busy && !data_pend_i) d.send_empty = 1'b1;
            end
            FK_REJ: begin
              if (ack_ok) begin
                d.dnr = rx_nr_i;
                d.ns = rx_nr_i; // go back to the rejected frame
              end
            end
            FK_SREJ: begin
              // no single frame resend; the requested frame and those after it are resent by guarding
              if (ack_ok) d.dnr = rx_nr_i;
            end
            default: begin
            end
          endcase
        end else if (tx_free) begin
          if (q.grd_cnt >= GUARD_CYC - 1) begin
            d.ns = q.dnr;
            d.grd_cnt = 32'h0;
          end else if (busy_i && q.ack_run) begin
            d.tx_vld = 1'b1;
            d.tx_kind = FK_RNR;
            d.tx_nr = q.nr;
            d.ack_run = 1'b0;
            d.rr_rep = 1'b1;
            d.rr_cnt = 32'h0;
          end else if (q.rr_rep && !busy_i && (q.rr_cnt == 32'h0 || q.rr_cnt >= RR_CYC - 1)) begin
            d.tx_vld = 1'b1;
            d.tx_kind = FK_RR;
            d.tx_nr = q.nr;
            d.rr_cnt = 32'h1;
          end else if ((data_pend_i || q.send_empty) && !q.peer_busy && outst < q.win) begin
            d.tx_vld = 1'b1;
            d.tx_kind = FK_I;
            d.tx_ns = q.ns;
            d.tx_nr = q.nr;
            d.tx_take = data_pend_i;
            d.send_empty = 1'b0;
            d.ns = q.ns + 3'h1;
            d.ack_run = 1'b0;
          end else if (q.ack_run && q.ack_cnt >= ack_lim - 1) begin
            d.tx_vld = 1'b1;
            d.tx_kind = FK_RR;
            d.tx_nr = q.nr;
            d.ack_run = 1'b0;
          end
        end
      end
      default: begin
        d.st = ST_DOWN;
      end
    endcase
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      q <= '0;
      q.st <= ST_DOWN;
      q.win <= `SHL_DEF_WIN;
      q.tx_kind <= FK_NONE;
    end else begin
      q <= d;
    end
  end

  assign tx_vld_o = q.tx_vld;
  assign tx_kind_o = q.tx_kind;
  assign tx_ns_o = q.tx_ns;
  assign tx_nr_o = q.tx_nr;
  assign tx_win_o = q.tx_win;
  assign tx_srej_cap_o = q.tx_srej_cap;
  assign tx_take_o = q.tx_take;
  assign rx_ok_o = q.rx_ok;
  assign rx_data_o = q.rx_data;
  assign rx_extra_o = q.rx_extra;
  assign rx_extra_data_o = q.rx_extra_data;
  assign link_up_o = q.up;
endmodule

/* shl_link_endpoint_chk.sv */
// Purpose: port checks for the link endpoint
// Assumes: shortened acknowledge count handed on by the bind
// Notes: bounds carry a few cycles of slack for registered outputs
`timescale 1ns/1ps
module shl_link_endpoint_chk #(
  parameter int unsigned ACK_CYC = 200
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [2:0] local_win_i,
  input wire logic rx_vld_i,
  input wire logic [7:0] rx_kind_i,
  input wire logic [2:0] rx_win_i,
  input wire logic tx_rdy_i,
  input wire logic tx_vld_o,
  input wire logic [7:0] tx_kind_o,
  input wire logic [2:0] tx_win_o,
  input wire logic rx_ok_o,
  input wire logic link_up_o
);
  localparam int ACK_LIM = ACK_CYC + 8;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic rx_rset = rx_vld_i && rx_kind_i == 8'h20;
  AST_RST_IDLE: assert property ($rose(resetn_i) |-> !link_up_o && !tx_vld_o)
    else $error("outputs active after reset");
  AST_DROP_DOWN: assert property (!link_up_o && rx_vld_i && !rx_rset |=> !rx_ok_o)
    else $error("frame delivered while link down");
  AST_UP_CAUSE: assert property ($rose(link_up_o) |-> $past(rx_vld_i))
    else $error("link up without a received frame");
  AST_START_RSET: assert property (start_i && !link_up_o && !tx_vld_o |=> tx_vld_o && tx_kind_o == 8'h20)
    else $error("start did not send reset frame");
  AST_UA_REPLY: assert property (rx_rset && rx_win_i >= 3'h2 && rx_win_i <= local_win_i && !tx_vld_o && !start_i
    |=> tx_vld_o && tx_kind_o == 8'h40)
    else $error("fitting reset frame not answered");
  AST_WIN_CUT: assert property (rx_rset && rx_win_i > local_win_i && local_win_i >= 3'h2 && !tx_vld_o && !start_i
    |=> tx_vld_o && tx_kind_o == 8'h20 && tx_win_o == local_win_i)
    else $error("large offer not answered with own reset");
  AST_ACK_BOUND: assert property (rx_ok_o |-> ##[1:ACK_LIM] tx_vld_o)
    else $error("received frame left unacknowledged");
  AST_TX_HOLD: assert property (tx_vld_o && !tx_rdy_i |=> tx_vld_o && $stable(tx_kind_o))
    else $error("transmit request dropped before accept");
  cover property ($rose(link_up_o));
  cover property (rx_ok_o);
  cover property (tx_vld_o && tx_kind_o == 8'h04);
endmodule
bind shl_link_endpoint shl_link_endpoint_chk #(.ACK_CYC(ACK_CYC)) i_chk (.clk_i(clk_i), .resetn_i(resetn_i),
  .start_i(start_i), .local_win_i(local_win_i), .rx_vld_i(rx_vld_i), .rx_kind_i(rx_kind_i), .rx_win_i(rx_win_i),
  .tx_rdy_i(tx_rdy_i), .tx_vld_o(tx_vld_o), .tx_kind_o(tx_kind_o), .tx_win_o(tx_win_o), .rx_ok_o(rx_ok_o),
  .link_up_o(link_up_o));

/* shl_peer_model.sv */
// Purpose: far endpoint, answers reset frames and forwards injected frames
// Assumes: injected frames win over automatic answers
// Notes: slow mode accepts on every other edge only
`timescale 1ns/1ps
module shl_peer_model (
  input wire logic clk_i,
  input wire logic ua_en_i,
  input wire logic slow_i,
  input wire logic inj_i,
  input wire logic [7:0] inj_kind_i,
  input wire logic [2:0] inj_ns_i,
  input wire logic [2:0] inj_win_i,
  input wire logic [7:0] inj_data_i,
  input wire logic tx_vld_i,
  input wire logic [7:0] tx_kind_i,
  output logic tx_rdy_o,
  output logic rx_vld_o,
  output logic [7:0] rx_kind_o,
  output logic [2:0] rx_ns_o,
  output logic [2:0] rx_win_o,
  output logic [7:0] rx_data_o
);
  logic ph_q = 1'h0;
  assign tx_rdy_o = !slow_i || ph_q;
  initial {rx_vld_o, rx_kind_o, rx_ns_o, rx_win_o, rx_data_o} = {1'h0, 8'h80, 3'h0, 3'h4, 8'h00};
  always @(posedge clk_i) begin
    ph_q <= !ph_q;
    if (inj_i) begin
      {rx_vld_o, rx_kind_o, rx_ns_o, rx_win_o, rx_data_o} <= {1'h1, inj_kind_i, inj_ns_i, inj_win_i, inj_data_i};
    end else if (ua_en_i && tx_vld_i && tx_rdy_o && tx_kind_i == 8'h20) begin
      // with ua_en_i set, each accepted reset frame is answered at once with UA, whatever its window
      {rx_vld_o, rx_kind_o} <= {1'h1, 8'h40};
    end else begin
      // released kind, number and data fields flip so a stale value never passes for a fresh one
      rx_vld_o <= 1'h0;
      {rx_kind_o, rx_ns_o, rx_data_o} <= ~{rx_kind_o, rx_ns_o, rx_data_o};
    end
  end
endmodule

/* shl_link_endpoint_test.sv */
// Purpose: directed scenarios for the link endpoint
// Assumes: shortened timer parameters
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`define CHK(got, exp) chk(32'(got), 32'(exp))
module shl_link_endpoint_test import shl_pkg::*;;
  logic clk_i = 1'h0, resetn_i = 1'h0, start_i = 1'h0, ua_en = 1'h1, slow = 1'h0, inj = 1'h0;
  logic [2:0] local_win_i = 3'h4, inj_ns = 3'h0, inj_win = 3'h4, rx_ns_i, rx_win_i, tx_nr_o, tx_win_o;
  logic [7:0] inj_kind = 8'h00, inj_data = 8'h00, rx_kind_i, rx_data_i, tx_kind_o, rx_data_o;
  logic rx_vld_i, tx_rdy_i, tx_vld_o, rx_ok_o, link_up_o, tx_take_o;
  logic busy = 1'h0, data_pend = 1'h0;
  logic [2:0] rx_nr = 3'h0, tx_ns_o;
  int mismatches = 0, check_count = 0, n;
  shl_link_endpoint #(.ACK_CYC(200), .GUARD_CYC(400), .CONN_CYC(200), .RR_CYC(300)) i_dut (.clk_i(clk_i),
    .resetn_i(resetn_i), .start_i(start_i), .local_win_i(local_win_i), .local_srej_i(1'h0), .busy_i(busy),
    .rx_vld_i(rx_vld_i), .rx_kind_i(rx_kind_i), .rx_ns_i(rx_ns_i), .rx_nr_i(rx_nr), .rx_win_i(rx_win_i),
    .rx_srej_cap_i(1'h0), .rx_data_i(rx_data_i), .data_pend_i(data_pend), .tx_rdy_i(tx_rdy_i),
    .tx_vld_o(tx_vld_o), .tx_kind_o(tx_kind_o), .tx_ns_o(tx_ns_o), .tx_nr_o(tx_nr_o), .tx_win_o(tx_win_o),
    .tx_srej_cap_o(), .tx_take_o(tx_take_o),
    .rx_ok_o(rx_ok_o), .rx_data_o(rx_data_o), .rx_extra_o(), .rx_extra_data_o(), .link_up_o(link_up_o));
  shl_peer_model i_peer (.clk_i(clk_i), .ua_en_i(ua_en), .slow_i(slow), .inj_i(inj), .inj_kind_i(inj_kind),
    .inj_ns_i(inj_ns), .inj_win_i(inj_win), .inj_data_i(inj_data), .tx_vld_i(tx_vld_o), .tx_kind_i(tx_kind_o),
    .tx_rdy_o(tx_rdy_i), .rx_vld_o(rx_vld_i), .rx_kind_o(rx_kind_i), .rx_ns_o(rx_ns_i), .rx_win_o(rx_win_i),
    .rx_data_o(rx_data_i));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic step(int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_tx(logic [7:0] k, int lim);
    n = 0;
    while (!(tx_vld_o === 1'h1 && tx_kind_o === k) && n < lim) begin
      step(1);
      n++;
    end
  endtask
  // the peer registers the frame, so delivery shows two edges later
  task automatic send(logic [7:0] k, logic [2:0] ns, logic [2:0] w, logic [7:0] d);
    {inj, inj_kind, inj_ns, inj_win, inj_data} = {1'h1, k, ns, w, d};
    step(1);
    inj = 1'h0;
    step(1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_down;
    `CHK(tx_kind_o, FK_NONE);
    send(FK_I, 3'h0, 3'h4, 8'h11);
    `CHK(rx_ok_o, 0);
    $display("test down done");
  endtask
  task automatic t_bringup;
    {ua_en, slow, start_i} = 3'b011;
    step(1);
    start_i = 1'h0;
    wait_tx(FK_RSET, 4);
    `CHK(tx_kind_o, FK_RSET);
    step(3);
    wait_tx(FK_RSET, 300);
    `CHK(tx_kind_o, FK_RSET);
    `CHK(n > 150, 1);
    `CHK(link_up_o, 0);
    {ua_en, slow} = 2'b10;
    step(4);
    `CHK(link_up_o, 1);
    $display("test bringup done");
  endtask
  task automatic t_data;
    send(FK_I, 3'h0, 3'h4, 8'h5A);
    `CHK(rx_ok_o, 1);
    `CHK(rx_data_o, 8'h5A);
    wait_tx(FK_RR, 250);
    `CHK(tx_kind_o, FK_RR);
    `CHK(tx_nr_o, 1);
    `CHK(n <= 200, 1);
    data_pend = 1'h1;
    wait_tx(FK_I, 4);
    data_pend = 1'h0;
    `CHK(tx_kind_o, FK_I);
    `CHK(tx_ns_o, 0);
    `CHK(tx_take_o, 1);
    $display("test data done");
  endtask
  task automatic t_gap;
    send(FK_I, 3'h3, 3'h4, 8'h33);
    `CHK(rx_ok_o, 0);
    wait_tx(FK_REJ, 4);
    `CHK(tx_kind_o, FK_REJ);
    `CHK(tx_nr_o, 1);
    $display("test gap done");
  endtask
  task automatic t_window;
    local_win_i = 3'h2;
    send(FK_RSET, 3'h0, 3'h4, 8'h00);
    wait_tx(FK_RSET, 4);
    `CHK(tx_kind_o, FK_RSET);
    `CHK(tx_win_o, 2);
    step(4);
    `CHK(link_up_o, 1);
    send(FK_RSET, 3'h0, 3'h2, 8'h00);
    wait_tx(FK_UA, 4);
    `CHK(tx_kind_o, FK_UA);
    $display("test window done");
  endtask
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    resetn_i = 1'h1;
    t_down;
    t_bringup;
    t_data;
    t_gap;
    t_window;
    conclude;
  end
  // the scenarios need under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    conclude;
  end
endmodule
